//--- core/pdc_defines.svh
/*
  Constants of the power-down, self-test and shared-pin control block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// register map, word addresses
`define PDC_ADDR_W          4
`define PDC_OFF_CTRL        4'h0
`define PDC_OFF_GPIO_OUT    4'h1
`define PDC_OFF_GPIO_OE     4'h2
`define PDC_OFF_FUNC_SEL    4'h3
`define PDC_OFF_STATUS      4'h4
`define PDC_OFF_GPIO_IN     4'h5

// field layout
`define PDC_NUM_GPIO        4
`define PDC_CTRL_AUDIO_EN   0
`define PDC_ST_ENABLE       0
`define PDC_ST_CLK_SEL      1
`define PDC_ST_IRQ_IN       2
`define PDC_ST_PLL_ON       3
`define PDC_ST_ACTIVE       4

// reset values: general io function, driving low
`define PDC_RST_GPIO_OUT    4'h0
`define PDC_RST_GPIO_OE     4'hF
`define PDC_RST_FUNC_SEL    4'h0
`define PDC_RST_CTRL        1'h0

// self-test clock choices
`define PDC_CLK_SEL_PIXEL   1'h0
`define PDC_CLK_SEL_33MHZ   1'h1

// pll settle after leaving power-down
`define PDC_PLL_LOCK_NS     1000
`define PDC_CLK_PERIOD_NS   100
`define PDC_PLL_LOCK_CYC    ((`PDC_PLL_LOCK_NS + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS)
`define PDC_CNT_W           4

`endif

//--- core/pdc_pkg.sv
/*
  Types of the power-down and pin control block.
  Assumes pdc_defines.svh is on the include path.
*/
`include "pdc_defines.svh"

package pdc_pkg;

  typedef enum logic [1:0] {
    PDC_DOWN,
    PDC_WAKE,
    PDC_RUN
  } pdc_state_t;

  typedef struct packed {
    logic [`PDC_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } pdc_bus_req_t;

  typedef struct packed {
    logic [`PDC_NUM_GPIO-1:0] o;
    logic [`PDC_NUM_GPIO-1:0] oe;
  } pdc_pin_drv_t;

  typedef struct packed {
    logic                     audio_data_out;
    logic                     audio_word_clk;
    logic                     audio_lane_c;
    logic                     audio_lane_d;
  } pdc_audio_t;

endpackage

//--- core/pdc_pin_ctrl.sv
/*
  Power-down sequencing, self-test pin decode and general io pin muxing.
  Assumes power_down_n, the self-test pins and io inputs come straight from pads
  and are synchronised here; audio signals come from logic on ref_clk_i.
*/
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

`include "pdc_defines.svh"

// Contract
// RL1 - power_down_n high: run, all state defaulted; here synchronisers and read data keep their values
// RL2 - power_down_n low: outputs tri-state, pll off
// RL3 - host holds power_down_n low until supplies
// RL4 - undriven power_down_n treated as low
// RL5 - self-test enable pin gates self-test mode
// RL6 - clock select: 0 pixel, 1 33MHz
// RL7 - shared pin is interrupt unless self-test
// RL8 - io zero: low default, else serial data
// RL9 - io one: low default, else word clock
// RL10 - io two: low default, else lane c
// RL11 - io three: low default, else lane d
// RL12 - function select cleared on power-down release
module pdc_pin_ctrl (
  // clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_b_i,
  // control pins from the host
  input  wire logic                         power_down_n_i,
  input  wire logic                         self_test_enable_pin_i,
  input  wire logic                         self_test_clock_select_i,
  // general io pads
  input  wire logic [`PDC_NUM_GPIO-1:0]     general_io_i,
  output logic      [`PDC_NUM_GPIO-1:0]     general_io_o,
  output logic      [`PDC_NUM_GPIO-1:0]     general_io_oe_o,
  // audio sources
  input  wire pdc_pkg::pdc_audio_t          audio_i,
  // register port
  input  wire pdc_pkg::pdc_bus_req_t        bus_i,
  output logic      [31:0]                  rdata_o,
  // status toward the device
  output logic                              device_active_o,
  output logic                              pll_enable_o,
  output logic                              self_test_mode_o,
  output logic                              self_test_clk_sel_o,
  output logic                              interrupt_input_pin_o
);
  import pdc_pkg::*;

  typedef struct packed {
    logic [1:0]                 pd_sync;
    logic [1:0]                 en_sync;
    logic [1:0]                 cs_sync;
    logic [`PDC_NUM_GPIO-1:0]   gin_s1;
    logic [`PDC_NUM_GPIO-1:0]   gin_s2;
    pdc_state_t                 state;
    logic [`PDC_CNT_W-1:0]      cnt;
    logic                       audio_en;
    logic [`PDC_NUM_GPIO-1:0]   gpio_out;
    logic [`PDC_NUM_GPIO-1:0]   gpio_oe;
    logic [`PDC_NUM_GPIO-1:0]   func_sel;
    pdc_pin_drv_t               drv;
    logic [31:0]                rdata;
    logic                       active;
    logic                       pll_on;
    logic                       st_mode;
    logic                       st_clk;
    logic                       irq_in;
  } pdc_regs_t;

  pdc_regs_t regs_ff;
  pdc_regs_t nxt_regs;

  // audio function per pin, in pin order
  logic [`PDC_NUM_GPIO-1:0] audio_vec;
  assign audio_vec = {audio_i.audio_lane_d, audio_i.audio_lane_c,
                      audio_i.audio_word_clk, audio_i.audio_data_out};

  function automatic logic hit(input logic [`PDC_ADDR_W-1:0] a, input logic [`PDC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // a pin leaves general io only with both enables set; shared by o and oe mux
  function automatic logic pin_is_audio(
    input logic en,
    input logic sel
  );
    pin_is_audio = en && sel;
  endfunction

  // shared pin as clock select: pixel clock unless self-test is on
  function automatic logic clk_sel_of(
    input logic st_on,
    input logic pin
  );
    clk_sel_of = st_on ? pin : `PDC_CLK_SEL_PIXEL;
  endfunction

  // shared pin as interrupt input: masked while self-test owns it
  function automatic logic irq_of(
    input logic st_on,
    input logic pin
  );
    irq_of = st_on ? 1'b0 : pin;
  endfunction

  // one bus write applied to a copy of the state
  function automatic pdc_regs_t write_regs(
    input pdc_regs_t    r,
    input pdc_bus_req_t b
  );
    pdc_regs_t n;
    n = r;
    if (hit(b.addr, `PDC_OFF_CTRL)) begin
      n.audio_en = b.wdata[`PDC_CTRL_AUDIO_EN];
    end
    if (hit(b.addr, `PDC_OFF_GPIO_OUT)) begin
      n.gpio_out = b.wdata[`PDC_NUM_GPIO-1:0];
    end
    if (hit(b.addr, `PDC_OFF_GPIO_OE)) begin
      n.gpio_oe = b.wdata[`PDC_NUM_GPIO-1:0];
    end
    if (hit(b.addr, `PDC_OFF_FUNC_SEL)) begin
      n.func_sel = b.wdata[`PDC_NUM_GPIO-1:0];
    end
    write_regs = n;
  endfunction

  // register read view; unmapped offsets read as zero
  function automatic logic [31:0] read_word(
    input pdc_regs_t              r,
    input logic [`PDC_ADDR_W-1:0] a
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `PDC_OFF_CTRL: begin
        w[`PDC_CTRL_AUDIO_EN] = r.audio_en;
      end
      `PDC_OFF_GPIO_OUT: begin
        w[`PDC_NUM_GPIO-1:0] = r.gpio_out;
      end
      `PDC_OFF_GPIO_OE: begin
        w[`PDC_NUM_GPIO-1:0] = r.gpio_oe;
      end
      `PDC_OFF_FUNC_SEL: begin
        w[`PDC_NUM_GPIO-1:0] = r.func_sel;
      end
      `PDC_OFF_GPIO_IN: begin
        w[`PDC_NUM_GPIO-1:0] = r.gin_s2;
      end
      `PDC_OFF_STATUS: begin
        w[`PDC_ST_ENABLE]  = r.st_mode;
        w[`PDC_ST_CLK_SEL] = r.st_clk;
        w[`PDC_ST_IRQ_IN]  = r.irq_in;
        w[`PDC_ST_PLL_ON]  = r.pll_on;
        w[`PDC_ST_ACTIVE]  = r.active;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    read_word = w;
  endfunction

  // power-down: pins and pll back to their defaults
  function automatic pdc_regs_t down_defaults(
    input pdc_regs_t r
  );
    pdc_regs_t n;
    n = r;
    n.state    = PDC_DOWN;
    n.cnt      = '0;
    n.audio_en = `PDC_RST_CTRL;
    n.gpio_out = `PDC_RST_GPIO_OUT;
    n.gpio_oe  = `PDC_RST_GPIO_OE;
    n.func_sel = `PDC_RST_FUNC_SEL; // RL12
    n.drv      = '0;
    n.pll_on   = 1'b0;
    n.active   = 1'b0;
    n.st_mode  = 1'b0;
    n.st_clk   = `PDC_CLK_SEL_PIXEL;
    n.irq_in   = 1'b0;
    down_defaults = n;
  endfunction

  logic                     powered;
  logic                     st_mode_now;
  logic [`PDC_NUM_GPIO-1:0] mux_o;
  logic [`PDC_NUM_GPIO-1:0] mux_oe;

  assign powered     = regs_ff.pd_sync[1];
  assign st_mode_now = regs_ff.en_sync[1];

  // per-pin function mux
  genvar gi;
  generate
    for (gi = 0; gi < `PDC_NUM_GPIO; gi++) begin : g_pin
      // pin gi: general io by default, audio only when selected
      assign mux_o[gi]  = pin_is_audio(regs_ff.audio_en, regs_ff.func_sel[gi]) ? audio_vec[gi] : regs_ff.gpio_out[gi];
      assign mux_oe[gi] = pin_is_audio(regs_ff.audio_en, regs_ff.func_sel[gi]) ? 1'b1 : regs_ff.gpio_oe[gi];
    end
  endgenerate

  always_comb begin
    nxt_regs = regs_ff;
    // pads come from the host domain; two stages before any use
    nxt_regs.pd_sync = {regs_ff.pd_sync[0], power_down_n_i};
    nxt_regs.en_sync = {regs_ff.en_sync[0], self_test_enable_pin_i};
    nxt_regs.cs_sync = {regs_ff.cs_sync[0], self_test_clock_select_i};
    nxt_regs.gin_s1  = general_io_i;
    nxt_regs.gin_s2  = regs_ff.gin_s1;
    nxt_regs.rdata   = 32'h0000_0000;

    case (regs_ff.state)
      PDC_DOWN: begin
        nxt_regs.pll_on = 1'b0;
        nxt_regs.active = 1'b0;
        nxt_regs.drv.oe = '0;
        // pad pulldown makes a floating pin read low, so we stay here  RL4
        if (powered) begin
          nxt_regs.state = PDC_WAKE;
          nxt_regs.cnt   = `PDC_CNT_W'(`PDC_PLL_LOCK_CYC);
        end
      end
      PDC_WAKE: begin
        nxt_regs.pll_on = 1'b1;
        nxt_regs.active = 1'b0;
        nxt_regs.drv.oe = '0;
        if (regs_ff.cnt == `PDC_CNT_W'(0)) begin
          nxt_regs.state = PDC_RUN;
        end else begin
          nxt_regs.cnt = regs_ff.cnt - `PDC_CNT_W'(1);
        end
      end
      PDC_RUN: begin
        // left only through the power-down pin, handled below
        nxt_regs.pll_on = 1'b1;
        nxt_regs.active = 1'b1;
        nxt_regs.drv.oe = mux_oe;
      end
      default: begin
        nxt_regs.state  = PDC_DOWN;
        nxt_regs.pll_on = 1'b0;
        nxt_regs.active = 1'b0;
        nxt_regs.drv.oe = '0;
      end
    endcase

    // register writes only while running
    if (regs_ff.state == PDC_RUN && bus_i.wr) begin
      nxt_regs = write_regs(nxt_regs, bus_i);
    end
    // read data stands for the one cycle after the strobe
    if (bus_i.rd) begin
      nxt_regs.rdata = read_word(regs_ff, bus_i.addr);
    end

    // self-test decode  RL5
    nxt_regs.st_mode = st_mode_now;
    // shared pin: clock select only in self-test, else interrupt input  RL7
    nxt_regs.st_clk = clk_sel_of(st_mode_now, regs_ff.cs_sync[1]); // RL6
    nxt_regs.irq_in = irq_of(st_mode_now, regs_ff.cs_sync[1]);

    nxt_regs.drv.o  = mux_o; // RL8 RL9 RL10 RL11

    // power-down: control, pin and status state back to defaults (synchronisers and read data kept), pads released, pll off  RL2
    if (!powered) begin
      nxt_regs = down_defaults(nxt_regs); // RL1
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      regs_ff.pd_sync  <= '0;
      regs_ff.en_sync  <= '0;
      regs_ff.cs_sync  <= '0;
      regs_ff.gin_s1   <= '0;
      regs_ff.gin_s2   <= '0;
      regs_ff.state    <= PDC_DOWN;
      regs_ff.cnt      <= '0;
      regs_ff.audio_en <= `PDC_RST_CTRL;
      regs_ff.gpio_out <= `PDC_RST_GPIO_OUT;
      regs_ff.gpio_oe  <= `PDC_RST_GPIO_OE;
      regs_ff.func_sel <= `PDC_RST_FUNC_SEL;
      regs_ff.drv      <= '0;
      regs_ff.rdata    <= '0;
      regs_ff.active   <= 1'b0;
      regs_ff.pll_on   <= 1'b0;
      regs_ff.st_mode  <= 1'b0;
      regs_ff.st_clk   <= `PDC_CLK_SEL_PIXEL;
      regs_ff.irq_in   <= 1'b0;
    end else begin
      regs_ff <= nxt_regs; // RL1
    end
  end

  assign general_io_o          = regs_ff.drv.o;
  assign general_io_oe_o       = regs_ff.drv.oe;
  assign rdata_o               = regs_ff.rdata;
  assign device_active_o       = regs_ff.active;
  assign pll_enable_o          = regs_ff.pll_on;
  assign self_test_mode_o      = regs_ff.st_mode;
  assign self_test_clk_sel_o   = regs_ff.st_clk;
  assign interrupt_input_pin_o = regs_ff.irq_in;

endmodule

`default_nettype wire

//--- testbench/pdc_pin_ctrl_chk.sv
/* assertions on the pin behaviour of pdc_pin_ctrl
   assumes one clock domain, bound to every pdc_pin_ctrl instance */
`timescale 1ns/10ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_pin_ctrl_chk (
  // clock, reset and host pins
  input wire logic                     ref_clk_i,
  input wire logic                     rst_b_i,
  input wire logic                     power_down_n_i,
  input wire logic                     self_test_enable_pin_i,
  input wire logic                     self_test_clock_select_i,
  // device outputs
  input wire logic [`PDC_NUM_GPIO-1:0] general_io_o,
  input wire logic [`PDC_NUM_GPIO-1:0] general_io_oe_o,
  input wire logic                     device_active_o,
  input wire logic                     pll_enable_o,
  input wire logic                     self_test_mode_o,
  input wire logic                     self_test_clk_sel_o,
  input wire logic                     interrupt_input_pin_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // six cycles leave room for the pad synchroniser
  sequence pd_held; !power_down_n_i [*6]; endsequence
  pd_tristate_a: assert property (pd_held |-> general_io_oe_o == 4'h0)
    else $error("io driven in power-down");
  pd_pll_off_a: assert property (pd_held |-> !pll_enable_o && !device_active_o)
    else $error("pll or device on in power-down");
  wake_active_a: assert property ($rose(power_down_n_i) ##1 power_down_n_i [*8] |-> ##[0:12] device_active_o)
    else $error("device did not wake");
  wake_default_a: assert property ($rose(device_active_o) |-> general_io_oe_o == 4'hF && general_io_o == 4'h0)
    else $error("io not low on wake");
  st_on_a: assert property ((device_active_o && self_test_enable_pin_i) [*6] |-> self_test_mode_o)
    else $error("self-test mode missing");
  st_off_a: assert property ((!self_test_enable_pin_i) [*6] |-> !self_test_mode_o)
    else $error("self-test mode without pin");
  st_clk_a: assert property ((self_test_mode_o && $stable(self_test_clock_select_i)) [*6] |->
    self_test_clk_sel_o == self_test_clock_select_i)
    else $error("self-test clock select wrong");
  irq_pass_a: assert property ((!self_test_enable_pin_i && $stable(self_test_clock_select_i)) [*6] ##0 device_active_o
    |-> interrupt_input_pin_o == self_test_clock_select_i)
    else $error("interrupt input not passed");
  cover property ($rose(device_active_o));
  cover property ($rose(self_test_mode_o));
  cover property (device_active_o && !power_down_n_i);
endmodule
bind pdc_pin_ctrl pdc_pin_ctrl_chk chk_i (.ref_clk_i, .rst_b_i, .power_down_n_i, .self_test_enable_pin_i,
  .self_test_clock_select_i, .general_io_o, .general_io_oe_o, .device_active_o, .pll_enable_o,
  .self_test_mode_o, .self_test_clk_sel_o, .interrupt_input_pin_o);
`default_nettype wire

//--- testbench/pdc_host_model.sv
/* host processor gpio model for power-down and self-test pins
   assumes the bench resolves the pulldown on the power-down wire */
`timescale 1ns/10ps
`default_nettype none
module pdc_host_model (
  // requests from the bench
  input  wire logic       ref_clk_i,
  input  wire logic       supply_ok_i,
  input  wire logic       float_i,
  input  wire logic [1:0] self_test_i,
  // pins toward the device
  output logic            power_down_n_o = 1'b0,
  output logic            power_down_n_oe_o = 1'b1,
  output logic [1:0]      self_test_o = 2'b00
);
  always @(posedge ref_clk_i) begin
    power_down_n_o    <= supply_ok_i;
    power_down_n_oe_o <= !float_i;
    self_test_o       <= self_test_i;
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
/* self-checking bench of pdc_pin_ctrl with a host pin model
   assumes design, checker and host model compiled before it */
`timescale 1ns/10ps
`default_nettype none
`include "pdc_defines.svh"
module tb;
  import pdc_pkg::*;
  logic         ref_clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic         supply_ok = 1'b0;
  logic         float_pd = 1'b0;
  logic [1:0]   st_req = 2'b00;
  logic [1:0]   st_pin;
  logic         pd_val, pd_oe, pll, active, st_mode, st_clk, irq;
  logic [3:0]   gio_in = 4'h0;
  logic [3:0]   gio_out, gio_oe;
  pdc_audio_t   audio = '0;
  pdc_bus_req_t bus = '0;
  logic [31:0]  rdata, v;
  logic [31:0]  exp_q[$];
  logic         rd_seen = 1'b0;
  int           num_errors = 0;
  int           n_tests = 0;
  int           cycles = 0;
  logic [31:0]  seed = 32'hE98B202B;
  wire          power_down_n = (pd_oe === 1'b1) ? pd_val : 1'b0;
  always #50 ref_clk_i = !ref_clk_i;
  pdc_host_model host (.ref_clk_i, .supply_ok_i(supply_ok), .float_i(float_pd), .self_test_i(st_req),
    .power_down_n_o(pd_val), .power_down_n_oe_o(pd_oe), .self_test_o(st_pin));
  pdc_pin_ctrl dut (.ref_clk_i, .rst_b_i, .power_down_n_i(power_down_n), .self_test_enable_pin_i(st_pin[1]),
    .self_test_clock_select_i(st_pin[0]), .general_io_i(gio_in), .general_io_o(gio_out), .general_io_oe_o(gio_oe),
    .audio_i(audio), .bus_i(bus), .rdata_o(rdata), .device_active_o(active), .pll_enable_o(pll),
    .self_test_mode_o(st_mode), .self_test_clk_sel_o(st_clk), .interrupt_input_pin_o(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read expectations are queued here and matched by the monitor
  task automatic bus_op(input logic wr, input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: d, wr: wr, rd: rd};
    if (rd) exp_q.push_back(d);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= bus.rd;
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    wait_n(4);
    rst_b_i <= 1'b1;
    float_pd <= 1'b1;
    wait_n(12);
    chk({pll, active, gio_oe}, 6'h00);
    $display("test power-down done");
    supply_ok <= 1'b1;
    float_pd <= 1'b0;
    wait_n(24);
    chk({pll, active, gio_oe, gio_out}, {2'b11, `PDC_RST_GPIO_OE, `PDC_RST_GPIO_OUT});
    bus_op(0, 1, `PDC_OFF_CTRL, `PDC_RST_CTRL);
    bus_op(0, 1, `PDC_OFF_GPIO_OE, `PDC_RST_GPIO_OE);
    bus_op(0, 1, `PDC_OFF_FUNC_SEL, `PDC_RST_FUNC_SEL);
    bus_op(0, 1, 4'hF, 32'h0);
    v = $random(seed);
    gio_in <= v[11:8];
    bus_op(1, 0, `PDC_OFF_GPIO_OUT, {28'h0, v[3:0]});
    bus_op(1, 0, `PDC_OFF_CTRL, 32'h1);
    bus_op(0, 1, `PDC_OFF_GPIO_OUT, {28'h0, v[3:0]});
    bus_op(0, 1, `PDC_OFF_GPIO_IN, {28'h0, v[11:8]});
    bus_op(0, 0, 4'h0, 32'h0);
    wait_n(3);
    chk(gio_out, v[3:0]);
    $display("test general io done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      audio <= v[7:4];
      bus_op(1, 0, `PDC_OFF_FUNC_SEL, 32'h1 << i);
      bus_op(0, 0, 4'h0, 32'h0);
      wait_n(3);
      chk(gio_out[i], v[7 - i]);
    end
    $display("test audio select done");
    for (int k = 0; k < 4; k++) begin
      st_req <= k[1:0];
      wait_n(8);
      chk({st_mode, k[1] ? st_clk : irq}, {k[1], k[0]});
      v = 32'h0000_0000;
      v[`PDC_ST_ENABLE]  = k[1];
      v[`PDC_ST_CLK_SEL] = k[1] & k[0];
      v[`PDC_ST_IRQ_IN]  = !k[1] & k[0];
      v[`PDC_ST_PLL_ON]  = 1'b1;
      v[`PDC_ST_ACTIVE]  = 1'b1;
      bus_op(0, 1, `PDC_OFF_STATUS, v);
      bus_op(0, 0, 4'h0, 32'h0);
    end
    $display("test self-test pins done");
    supply_ok <= 1'b0;
    wait_n(10);
    chk({pll, active, gio_oe}, 6'h00);
    supply_ok <= 1'b1;
    wait_n(24);
    bus_op(0, 1, `PDC_OFF_FUNC_SEL, `PDC_RST_FUNC_SEL);
    bus_op(0, 0, 4'h0, 32'h0);
    wait_n(2);
    chk(gio_out, `PDC_RST_GPIO_OUT);
    $display("test power cycle done");
    print_verdict();
  end
endmodule
`default_nettype wire
